// >>> dcg_crc_regs.sv
`timescale 1ns/1ns
module dcg_crc_regs
  import dcg_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  // Data words from the DMA channel, one word per valid cycle.
  input wire logic [DATA_W-1:0] dmaData,
  input wire logic dmaValid,
  // Result as seen by software, registered.
  output logic [DATA_W-1:0] crcResult
);

  // --------------------------------------------------------------------
  // Helper functions.
  // --------------------------------------------------------------------

  // Mask of valid result bits: length field + 1 stages take part.
  function automatic logic [DATA_W-1:0] lenMask(input logic [CTL_LEN_W-1:0] len);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (i <= int'(len))
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // One's complement 16-bit add with end-around carry.
  function automatic logic [CSUM_W-1:0] onesAdd(input logic [CSUM_W-1:0] a, input logic [CSUM_W-1:0] b);
    logic [CSUM_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    s = {1'b0, s[CSUM_W-1:0]} + {{CSUM_W{1'b0}}, s[CSUM_W]};
    return s[CSUM_W-1:0];
  endfunction

  // --------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] control_ff, nxt_control;
  logic [DATA_W-1:0] taps_ff, nxt_taps;
  logic [DATA_W-1:0] lfsr_ff, nxt_lfsr;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [DATA_W-1:0] result_ff, nxt_result;
  logic [DATA_W-1:0] lfsrStep;
  logic [DATA_W-1:0] validMask;
  logic [CSUM_W-1:0] sumStep;
  logic ipMode;
  logic fb;

  assign ipMode = control_ff[CTL_TYPE_BIT];
  assign validMask = lenMask(control_ff[CTL_LEN_LSB +: CTL_LEN_W]);

  // --------------------------------------------------------------------
  // Next-state logic.
  // --------------------------------------------------------------------
  // The shift engine consumes one input bit per valid cycle (bit 0 of the DMA
  // word), trading throughput for a tiny datapath.
  always_comb
  begin
    fb = lfsr_ff[control_ff[CTL_LEN_LSB +: CTL_LEN_W]] ^ dmaData[0];
    lfsrStep = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (i == 0)
      begin
        lfsrStep[i] = fb;
      end
      else if (taps_ff[i])
      begin
        lfsrStep[i] = lfsr_ff[i-1] ^ fb;
      end
      else
      begin
        lfsrStep[i] = lfsr_ff[i-1];
      end
    end
    lfsrStep = lfsrStep & validMask;
    // Checksum held internally as the true sum; read shows its complement.
    sumStep = onesAdd(onesAdd(lfsr_ff[CSUM_W-1:0], dmaData[CSUM_W-1:0]), dmaData[DATA_W-1:CSUM_W]);

    nxt_control = control_ff;
    nxt_taps = taps_ff;
    nxt_lfsr = lfsr_ff;
    if (dmaValid)
    begin
      if (ipMode)
      begin
        nxt_lfsr = {{(DATA_W-CSUM_W){1'b0}}, sumStep};
      end
      else
      begin
        nxt_lfsr = lfsrStep;
      end
    end
    if (regWrite)
    begin
      case (regAddr)
        ADDR_CONTROL: nxt_control = regWdata;
        ADDR_TAPS: nxt_taps = regWdata;
        ADDR_RESULT: nxt_lfsr = regWdata;
        default: nxt_control = control_ff;
      endcase
    end

    if (ipMode)
    begin
      nxt_result = {{(DATA_W-CSUM_W){1'b0}}, ~nxt_lfsr[CSUM_W-1:0]};
    end
    else
    begin
      nxt_result = nxt_lfsr & validMask;
    end

    nxt_rdata = READ_ZERO;
    if (regRead)
    begin
      case (regAddr)
        ADDR_CONTROL: nxt_rdata = control_ff;
        ADDR_TAPS: nxt_rdata = taps_ff;
        ADDR_RESULT: nxt_rdata = result_ff;
        default: nxt_rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_ff <= RESET_WORD;
      taps_ff <= RESET_WORD;
      lfsr_ff <= RESET_WORD;
      rdata_ff <= RESET_WORD;
      result_ff <= RESET_WORD;
    end
    else
    begin
      control_ff <= nxt_control;
      taps_ff <= nxt_taps;
      lfsr_ff <= nxt_lfsr;
      rdata_ff <= nxt_rdata;
      result_ff <= nxt_result;
    end
  end

  assign regRdata = rdata_ff;
  assign crcResult = result_ff;

  // --------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------
  chk_seed_load: assert property (@(posedge clk) disable iff (rst)
    (regWrite && regAddr == ADDR_RESULT && !control_ff[CTL_TYPE_BIT]) |=> lfsr_ff == $past(regWdata))
    else $error("seed write not loaded");
  chk_read_value: assert property (@(posedge clk) disable iff (rst)
    (regRead && regAddr == ADDR_RESULT) |=> regRdata == $past(result_ff))
    else $error("result read wrong");
  chk_read_keeps: assert property (@(posedge clk) disable iff (rst)
    (regRead && !regWrite && !dmaValid) |=> $stable(lfsr_ff))
    else $error("read altered value");
  chk_upper_zero: assert property (@(posedge clk) disable iff (rst)
    ipMode && $stable(control_ff) |-> crcResult[DATA_W-1:CSUM_W] == '0)
    else $error("upper checksum bits set");
  chk_ones_form: assert property (@(posedge clk) disable iff (rst)
    (ipMode && regWrite && regAddr == ADDR_RESULT) |=> crcResult[CSUM_W-1:0] == ~$past(regWdata[CSUM_W-1:0]))
    else $error("checksum not complemented");
  chk_len_mask: assert property (@(posedge clk) disable iff (rst)
    !ipMode && $stable(control_ff) |-> (crcResult & ~validMask) == '0)
    else $error("bits above length set");
  chk_tap_ignore: assert property (@(posedge clk) disable iff (rst)
    (ipMode && dmaValid && !regWrite) |=> lfsr_ff[CSUM_W-1:0] == $past(sumStep))
    else $error("checksum step wrong");
  chk_tap_feed: assert property (@(posedge clk) disable iff (rst)
    (!ipMode && dmaValid && !regWrite) |=> lfsr_ff == $past(lfsrStep))
    else $error("shift step wrong");
endmodule

// >>> dcg_pkg.sv
package dcg_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_TAPS = 4'h8;
  localparam int CTL_TYPE_BIT = 15;
  localparam int CTL_LEN_LSB = 8;
  localparam int CTL_LEN_W = 5;
  localparam int CSUM_W = 16;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage

// >>> dcg_dma_model.sv
`timescale 1ns/1ns
module dcg_dma_model
  import dcg_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Request from the bench.
  input wire logic [DATA_W-1:0] sendWord,
  input wire logic sendReq,
  // Word stream.
  output logic [DATA_W-1:0] dmaData = '0,
  output logic dmaValid = 1'b0
);
  // Idle data toggles every cycle, so a stray consume corrupts the result.
  always_ff @(posedge clk)
  begin
    dmaValid <= sendReq;
    dmaData <= sendReq ? sendWord : ~dmaData;
  end
endmodule

// >>> dcg_crc_regs_tb.sv
`timescale 1ns/1ns
module dcg_crc_regs_tb
  import dcg_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWdata = 32'h0, sendWord = 32'h0, regRdata, crcResult, dmaData, st, taps, t;
  logic regWrite = 1'b0, regRead = 1'b0, sendReq = 1'b0, rdPend = 1'b0, dmaValid, csum, fb;
  logic [DATA_W-1:0] q[$];
  logic [15:0] sum;
  int lens[4] = '{0, 7, 19, 31};
  int lenSel, error_cnt = 0, n_tests = 0;
  dcg_crc_regs i_dut(.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .dmaData(dmaData), .dmaValid(dmaValid), .crcResult(crcResult));
  dcg_dma_model i_dma(.clk(clk), .sendWord(sendWord), .sendReq(sendReq), .dmaData(dmaData), .dmaValid(dmaValid));
  initial forever #5 clk = ~clk;
  function automatic logic [DATA_W-1:0] expRd();
    return csum ? {16'h0000, ~sum} : st & (32'hFFFF_FFFF >> (31 - lenSel));
  endfunction
  task automatic chk(string nm, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    q.push_back(e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic seed(logic [DATA_W-1:0] d);
    wr(ADDR_RESULT, d);
    st = d;
    sum = d[15:0];
  endtask
  task automatic send(logic [DATA_W-1:0] d);
    sendWord <= d;
    sendReq <= 1'b1;
    @(posedge clk);
    sendReq <= 1'b0;
    repeat (2) @(posedge clk);
    fb = st[lenSel] ^ d[0];
    st = {st[30:0], fb} ^ ({taps[31:1], 1'b0} & {32{fb}});
    t = 32'(sum) + 32'(d[15:0]) + 32'(d[31:16]);
    t = 32'(t[15:0]) + 32'(t[31:16]);
    t = 32'(t[15:0]) + 32'(t[31:16]);
    if (csum)
      sum = t[15:0];
  endtask
  always @(posedge clk)
  begin
    if (rdPend)
      chk("regRdata", regRdata, q.pop_front());
    rdPend <= regRead;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  initial
  begin
    void'($urandom(25998));
    csum = 1'b0;
    lenSel = 31;
    st = RESET_WORD;
    sum = 16'h0000;
    taps = RESET_WORD;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_RESULT, RESET_WORD);
    rd(ADDR_TAPS, RESET_WORD);
    rd(4'hC, READ_ZERO);
    foreach (lens[i])
    begin
      lenSel = lens[i];
      taps = $urandom;
      wr(ADDR_CONTROL, DATA_W'(lenSel) << CTL_LEN_LSB);
      wr(ADDR_TAPS, taps);
      rd(ADDR_TAPS, taps);
      seed($urandom);
      rd(ADDR_RESULT, expRd());
      repeat (6) send($urandom);
      rd(ADDR_RESULT, expRd());
      rd(ADDR_RESULT, expRd());
      chk("crcResult", crcResult, expRd());
    end
    csum = 1'b1;
    wr(ADDR_CONTROL, 32'h0000_0001 << CTL_TYPE_BIT);
    seed(32'hFFFF_0000);
    rd(ADDR_RESULT, expRd());
    seed($urandom);
    rd(ADDR_RESULT, expRd());
    repeat (4) send($urandom);
    wr(ADDR_TAPS, $urandom);
    send($urandom);
    rd(ADDR_RESULT, expRd());
    chk("crcResult", crcResult, expRd());
    stop_test();
  end
endmodule
